// [design/mcr_pkg.sv]
package mcr_pkg;

    // register offsets
    localparam logic [7:0] ADDR_R2_OFFSET = 8'h72;
    localparam logic [7:0] ADDR_FAN_CFG = 8'h73;
    localparam logic [7:0] ADDR_ALERT_MASK1 = 8'h74;

    // values after reset
    localparam logic [7:0] RST_R2_OFFSET = 8'h00;
    localparam logic [7:0] RST_FAN_CFG = 8'h00;
    localparam logic [7:0] RST_ALERT_MASK1 = 8'h00;
    localparam logic [7:0] RST_RDATA = 8'h00;
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

    // fan detect / conversion config fields
    localparam int CFG_FAN_DET_EN = 0;
    localparam int CFG_PRES_LSB = 1;
    localparam int CFG_PRES_MSB = 3;
    localparam int CFG_AVG_OFF = 4;
    localparam int CFG_ATTENUATOR_BYPASS_ALL_ALL = 5;
    localparam int CFG_SINGLE_CHANNEL_CONVERT_ONE = 6;
    localparam int CFG_SHUTDOWN = 7;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hF1;

    // alert mask 1 fields
    localparam int MSK_V25_OVERTEMP_PIN = 0;
    localparam int MSK_VCORE = 1;
    localparam int MSK_VSUPPLY = 2;
    localparam int MSK_V5 = 3;
    localparam int MSK_REMOTE1 = 4;
    localparam int MSK_LOCAL = 5;
    localparam int MSK_REMOTE2 = 6;
    localparam int MSK_OOL = 7;

    // remote 2 offset scaling, in quarter-degree measurement steps
    localparam int OFS_SHIFT_FINE = 1;
    localparam int OFS_SHIFT_COARSE = 2;
    localparam int TEMP_W = 10;
    localparam int SUM_W = 12;

    localparam int SYNC_STAGES = 3;
    localparam int NUM_CHAN = 10;

    typedef enum logic [3:0] {
        MCR_CH_V25 = 4'b0000,
        MCR_CH_VCORE = 4'b0001,
        MCR_CH_VSUPPLY = 4'b0010,
        MCR_CH_V5 = 4'b0011,
        MCR_CH_V12 = 4'b0100,
        MCR_CH_REMOTE1 = 4'b0101,
        MCR_CH_LOCAL = 4'b0110,
        MCR_CH_REMOTE2 = 4'b0111,
        MCR_CH_VTERM = 4'b1000,
        MCR_CH_IMON = 4'b1001
    } mcr_chan_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } mcr_reg_req_t;

    // bit order matches alert mask 1
    typedef struct packed {
        logic summary_out_of_limit;
        logic remote2;
        logic local_t;
        logic remote1;
        logic v5;
        logic vsupply;
        logic vcore;
        logic v25_or_overtemp_pin;
    } mcr_stat_t;

    // attenuator_bypass_all_bypass order: [0] +2.5V, [1] core, [2] +5V, [3] +12V
    typedef struct packed {
        logic shutdown;
        logic monitor_run;
        logic single_channel_convert;
        logic averaging_disable;
        logic [3:0] attenuator_bypass_all_bypass;
        logic [9:0] single_channel_convert_sel_onehot;
    } mcr_mode_t;

endpackage

// [design/mcr_regs.sv]
module mcr_regs
    import mcr_pkg::*;
#(
    parameter int NUM_FANS = 3
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire mcr_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic lock_active,
    input wire logic offset_range_coarse,
    input wire logic [3:0] attenuator_bypass_all_bypass_chan,
    input wire logic [3:0] single_chan_code,
    input wire logic [NUM_FANS-1:0] four_wire_present_pin,
    input wire logic [TEMP_W-1:0] remote2_meas,
    input wire logic remote2_meas_valid,
    output logic [TEMP_W-1:0] remote2_adj,
    output logic remote2_adj_valid,
    input wire mcr_stat_t alert_status,
    input wire logic alert_other,
    output logic alert_o,
    output logic alert_oe,
    output mcr_mode_t mode
);

    logic [7:0] r2_offset_ff;
    logic [7:0] fan_cfg_ff;
    logic [7:0] alert_mask1_ff;
    logic [7:0] rdata_ff;
    logic rvalid_ff;
    logic [TEMP_W-1:0] r2_adj_ff;
    logic r2_adj_valid_ff;
    logic alert_oe_ff;
    mcr_mode_t mode_ff;

    logic [NUM_FANS-1:0] four_wire_present;
    logic [2:0] presence_bits;
    logic [7:0] fan_cfg_view;
    logic wr_offset;
    logic wr_fan_cfg;
    logic wr_mask1;
    logic [7:0] nxt_rdata;
    logic [TEMP_W-1:0] nxt_r2_adj;
    logic nxt_alert_oe;
    mcr_mode_t nxt_mode;

    // one-hot channel select, out-of-range codes select nothing
    function automatic logic [NUM_CHAN-1:0] chan_onehot(
        input logic [3:0] code
    );
        logic [NUM_CHAN-1:0] sel;
        sel = '0;
        case (code)
            MCR_CH_V25: sel[0] = 1'b1;
            MCR_CH_VCORE: sel[1] = 1'b1;
            MCR_CH_VSUPPLY: sel[2] = 1'b1;
            MCR_CH_V5: sel[3] = 1'b1;
            MCR_CH_V12: sel[4] = 1'b1;
            MCR_CH_REMOTE1: sel[5] = 1'b1;
            MCR_CH_LOCAL: sel[6] = 1'b1;
            MCR_CH_REMOTE2: sel[7] = 1'b1;
            MCR_CH_VTERM: sel[8] = 1'b1;
            MCR_CH_IMON: sel[9] = 1'b1;
            default: sel = '0;
        endcase
        return sel;
    endfunction

    // signed add with clamp to the measurement range
    function automatic logic [TEMP_W-1:0] add_offset(
        input logic [TEMP_W-1:0] meas,
        input logic [7:0] ofs,
        input logic coarse
    );
        logic signed [SUM_W-1:0] m;
        logic signed [SUM_W-1:0] o;
        logic signed [SUM_W-1:0] s;
        logic signed [SUM_W-1:0] hi;
        logic signed [SUM_W-1:0] lo;
        m = SUM_W'(signed'(meas));
        o = SUM_W'(signed'(ofs));
        if (coarse) begin
            o = o <<< OFS_SHIFT_COARSE;
        end else begin
            o = o <<< OFS_SHIFT_FINE;
        end
        s = m + o;
        hi = SUM_W'((1 << (TEMP_W - 1)) - 1);
        lo = -SUM_W'(1 << (TEMP_W - 1));
        if (s > hi) begin
            s = hi;
        end else if (s < lo) begin
            s = lo;
        end
        return s[TEMP_W-1:0];
    endfunction

    mcr_sync3 #(
        .WIDTH(NUM_FANS)
    ) u_fan_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .async_in(four_wire_present_pin),
        .sync_out(four_wire_present)
    );

    // write decode, lock blocks the offset and fan config
    assign wr_offset = reg_req.wr && (reg_req.addr == ADDR_R2_OFFSET)
        && !lock_active;
    assign wr_fan_cfg = reg_req.wr && (reg_req.addr == ADDR_FAN_CFG)
        && !lock_active;
    assign wr_mask1 = reg_req.wr && (reg_req.addr == ADDR_ALERT_MASK1);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            r2_offset_ff <= RST_R2_OFFSET;
        end else if (wr_offset) begin
            r2_offset_ff <= reg_req.wdata;
        end
    end

    // presence bits are never stored from a write
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fan_cfg_ff <= RST_FAN_CFG;
        end else if (wr_fan_cfg) begin
            fan_cfg_ff <= reg_req.wdata & CFG_WRITE_MASK;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            alert_mask1_ff <= RST_ALERT_MASK1;
        end else if (wr_mask1) begin
            alert_mask1_ff <= reg_req.wdata;
        end
    end

    // presence shows only while detection is enabled
    always_comb begin
        presence_bits = '0;
        if (fan_cfg_ff[CFG_FAN_DET_EN]) begin
            presence_bits = 3'(four_wire_present);
        end
        fan_cfg_view = fan_cfg_ff;
        fan_cfg_view[CFG_PRES_MSB:CFG_PRES_LSB] = presence_bits;
    end

    always_comb begin
        case (reg_req.addr)
            ADDR_R2_OFFSET: nxt_rdata = r2_offset_ff;
            ADDR_FAN_CFG: nxt_rdata = fan_cfg_view;
            ADDR_ALERT_MASK1: nxt_rdata = alert_mask1_ff;
            default: nxt_rdata = UNMAPPED_RDATA;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= RST_RDATA;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_req.rd;
            if (reg_req.rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // offset applied to every remote 2 result
    assign nxt_r2_adj = add_offset(remote2_meas, r2_offset_ff,
        offset_range_coarse);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            r2_adj_ff <= '0;
            r2_adj_valid_ff <= 1'b0;
        end else begin
            r2_adj_valid_ff <= remote2_meas_valid;
            if (remote2_meas_valid) begin
                r2_adj_ff <= nxt_r2_adj;
            end
        end
    end

    // mode controls for the measurement engine
    always_comb begin
        nxt_mode.shutdown = fan_cfg_ff[CFG_SHUTDOWN];
        nxt_mode.monitor_run = !fan_cfg_ff[CFG_SHUTDOWN];
        nxt_mode.averaging_disable = fan_cfg_ff[CFG_AVG_OFF];
        nxt_mode.attenuator_bypass_all_bypass = {4{fan_cfg_ff[CFG_ATTENUATOR_BYPASS_ALL_ALL]}}
            | attenuator_bypass_all_bypass_chan;
        nxt_mode.single_channel_convert =
            fan_cfg_ff[CFG_SINGLE_CHANNEL_CONVERT_ONE];
        if (fan_cfg_ff[CFG_SINGLE_CHANNEL_CONVERT_ONE]) begin
            nxt_mode.single_channel_convert_sel_onehot =
                chan_onehot(single_chan_code);
        end else begin
            nxt_mode.single_channel_convert_sel_onehot = '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode_ff <= '{default: 1'b0};
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // summary mask is separate from any second-status source masks
    always_comb begin
        nxt_alert_oe = alert_other
            | (alert_status.v25_or_overtemp_pin
                & !alert_mask1_ff[MSK_V25_OVERTEMP_PIN])
            | (alert_status.vcore & !alert_mask1_ff[MSK_VCORE])
            | (alert_status.vsupply
                & !alert_mask1_ff[MSK_VSUPPLY])
            | (alert_status.v5 & !alert_mask1_ff[MSK_V5])
            | (alert_status.remote1
                & !alert_mask1_ff[MSK_REMOTE1])
            | (alert_status.local_t & !alert_mask1_ff[MSK_LOCAL])
            | (alert_status.remote2
                & !alert_mask1_ff[MSK_REMOTE2])
            | (alert_status.summary_out_of_limit
                & !alert_mask1_ff[MSK_OOL]);
    end

    // open-drain alert: enable high pulls the pin low
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            alert_oe_ff <= 1'b0;
        end else begin
            alert_oe_ff <= nxt_alert_oe;
        end
    end

    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;
    assign remote2_adj = r2_adj_ff;
    assign remote2_adj_valid = r2_adj_valid_ff;
    assign alert_o = 1'b0;
    assign alert_oe = alert_oe_ff;
    assign mode = mode_ff;

endmodule

// [design/mcr_sync3.sv]
module mcr_sync3 #(
    parameter int WIDTH = 3
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] out_ff;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            out_ff <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    out_ff[i] <= s3_ff[i];
                end
            end
        end
    end

    assign sync_out = out_ff;
endmodule

// [tb/mcr_host_model.sv]
module mcr_host_model
    import mcr_pkg::*;
(
    input wire logic mclk,
    output mcr_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial reg_req = '0;

    // released address and data show the inverse, not the last value
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge mclk);
        reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge mclk);
        reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
        @(posedge mclk);
        #1;
        d = reg_rdata;
    endtask
endmodule

// [tb/mcr_regs_checker.sv]
module mcr_regs_checker
    import mcr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire mcr_reg_req_t reg_req,
    input wire logic reg_rvalid,
    input wire logic lock_active,
    input wire logic remote2_meas_valid,
    input wire logic remote2_adj_valid,
    input wire mcr_stat_t alert_status,
    input wire logic alert_other,
    input wire logic alert_o,
    input wire logic alert_oe,
    input wire mcr_mode_t mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic cfg_wr;
    assign cfg_wr = reg_req.wr && reg_req.addr == ADDR_FAN_CFG;

    property p_rvalid;
        reg_req.rd |=> reg_rvalid;
    endproperty
    a_rvalid:
        assert property (p_rvalid) else $error("read answer missing");
    property p_rvalid_idle;
        !reg_req.rd |=> !reg_rvalid;
    endproperty
    a_rvalid_idle:
        assert property (p_rvalid_idle) else $error("read answer stray");
    property p_adj_valid;
        remote2_meas_valid |=> remote2_adj_valid;
    endproperty
    a_adj_valid:
        assert property (p_adj_valid) else $error("adjusted reading late");
    property p_locked;
        lock_active && cfg_wr |-> ##2
            ($stable(mode.shutdown) && $stable(mode.averaging_disable));
    endproperty
    a_locked:
        assert property (p_locked) else $error("locked config changed");
    property p_avg;
        !lock_active && cfg_wr ##1 !reg_req.wr |=>
            mode.averaging_disable == $past(reg_req.wdata[CFG_AVG_OFF], 2);
    endproperty
    a_avg:
        assert property (p_avg) else $error("averaging bit not applied");
    property p_shutdown;
        !lock_active && cfg_wr ##1 !reg_req.wr |=>
            mode.shutdown == $past(reg_req.wdata[CFG_SHUTDOWN], 2);
    endproperty
    a_shutdown:
        assert property (p_shutdown) else $error("shutdown bit not applied");
    property p_single_off;
        !mode.single_channel_convert |-> mode.single_channel_convert_sel_onehot == '0;
    endproperty
    a_single_off:
        assert property (p_single_off) else $error("channel select leaks");
    property p_onehot;
        $onehot0(mode.single_channel_convert_sel_onehot);
    endproperty
    a_onehot:
        assert property (p_onehot) else $error("several channels selected");
    property p_alert_quiet;
        alert_status == '0 && !alert_other |=> !alert_oe;
    endproperty
    a_alert_quiet:
        assert property (p_alert_quiet) else $error("alert without cause");
    property p_alert_other;
        alert_other |=> alert_oe;
    endproperty
    a_alert_other:
        assert property (p_alert_other) else $error("alert request lost");
    property p_alert_low;
        alert_o == 1'b0;
    endproperty
    a_alert_low:
        assert property (p_alert_low) else $error("alert data not low");
endmodule

bind mcr_regs mcr_regs_checker u_chk (.mclk, .rst_b, .reg_req, .reg_rvalid,
    .lock_active,
    .remote2_meas_valid, .remote2_adj_valid, .alert_status, .alert_other,
    .alert_o, .alert_oe, .mode);

// [tb/tb_monitor_config_and_alert_mask_regs.sv]
module tb_monitor_config_and_alert_mask_regs;
    import mcr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_b, lock_active, offset_range_coarse, remote2_meas_valid;
    logic alert_other, alert_o, alert_oe, reg_rvalid, remote2_adj_valid;
    logic [3:0] attenuator_bypass_all_bypass_chan, single_chan_code;
    logic [2:0] pres;
    logic [9:0] remote2_meas, remote2_adj;
    logic [7:0] reg_rdata, d;
    mcr_reg_req_t reg_req;
    mcr_stat_t alert_status;
    mcr_mode_t mode;
    int fails, checked, cyc;

    mcr_regs uut (.mclk, .rst_b, .reg_req, .reg_rdata, .reg_rvalid,
        .lock_active, .offset_range_coarse, .attenuator_bypass_all_bypass_chan,
        .single_chan_code, .four_wire_present_pin(pres), .remote2_meas,
        .remote2_meas_valid, .remote2_adj, .remote2_adj_valid, .alert_status,
        .alert_other, .alert_o, .alert_oe, .mode);
    mcr_host_model host (.mclk, .reg_req, .reg_rdata);

    always #12.5 mclk = ~mclk;

    task automatic report_and_stop;
        $display("fails=%0d checked=%0d", fails, checked);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            report_and_stop;
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        host.rd_reg(a, d);
        chk(d, exp);
    endtask

    // let registered outputs land
    task automatic cyc2;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic alert_case(input logic [7:0] st, input logic [7:0] m,
                              input logic exp);
        host.wr_reg(ADDR_ALERT_MASK1, m);
        @(posedge mclk) alert_status <= st;
        cyc2;
        chk(alert_oe, exp);
    endtask

    task automatic meas_case(input logic [7:0] o, input logic c,
                             input logic [9:0] exp);
        host.wr_reg(ADDR_R2_OFFSET, o);
        @(posedge mclk) begin
            offset_range_coarse <= c;
            remote2_meas_valid <= 1'b1;
        end
        @(posedge mclk) remote2_meas_valid <= 1'b0;
        #1;
        chk(remote2_adj_valid, 1'b1);
        chk(remote2_adj, exp);
    endtask

    initial begin
        {rst_b, lock_active, offset_range_coarse, remote2_meas_valid} = '0;
        alert_other = 1'b0;
        attenuator_bypass_all_bypass_chan = 4'h0;
        single_chan_code = 4'h0;
        pres = 3'b101;
        remote2_meas = 10'h010;
        alert_status = '0;
        fails = 0;
        checked = 0;
        cyc = 0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        rdc(ADDR_R2_OFFSET, 8'h00);
        rdc(ADDR_FAN_CFG, 8'h00);
        rdc(ADDR_ALERT_MASK1, 8'h00);
        rdc(8'h75, 8'h00);
        host.wr_reg(ADDR_R2_OFFSET, 8'hA5);
        rdc(ADDR_R2_OFFSET, 8'hA5);
        host.wr_reg(ADDR_FAN_CFG, 8'hFF);
        rdc(ADDR_FAN_CFG, 8'hFB);
        chk(mode.averaging_disable, 1'b1);
        chk(mode.attenuator_bypass_all_bypass, 4'hF);
        chk(mode.shutdown, 1'b1);
        chk(mode.monitor_run, 1'b0);
        host.wr_reg(ADDR_FAN_CFG, 8'h40);
        @(posedge mclk) attenuator_bypass_all_bypass_chan <= 4'h2;
        for (int c = 0; c < 10; c++) begin
            @(posedge mclk) single_chan_code <= 4'(c);
            cyc2;
            chk(mode.single_channel_convert_sel_onehot, 10'h001 << c);
        end
        chk(mode.attenuator_bypass_all_bypass, 4'h2);
        chk(mode.monitor_run, 1'b1);
        @(posedge mclk) lock_active <= 1'b1;
        host.wr_reg(ADDR_R2_OFFSET, 8'h11);
        host.wr_reg(ADDR_FAN_CFG, 8'h81);
        rdc(ADDR_R2_OFFSET, 8'hA5);
        rdc(ADDR_FAN_CFG, 8'h40);
        @(posedge mclk) lock_active <= 1'b0;
        meas_case(8'h04, 1'b0, 10'h018);
        meas_case(8'h04, 1'b1, 10'h020);
        meas_case(8'hFC, 1'b1, 10'h000);
        meas_case(8'h7F, 1'b1, 10'h1FF);
        for (int i = 0; i < 8; i++) begin
            alert_case(8'h01 << i, 8'h00, 1'b1);
            alert_case(8'h01 << i, 8'h01 << i, 1'b0);
            alert_case(8'h01 << i, ~(8'h01 << i), 1'b1);
        end
        alert_case(8'hFF, 8'hFF, 1'b0);
        @(posedge mclk) alert_other <= 1'b1;
        cyc2;
        chk(alert_oe, 1'b1);
        chk(alert_o, 1'b0);
        @(posedge mclk) alert_other <= 1'b0;
        report_and_stop;
    end
endmodule
